//--- shared/pmt_pkg.sv
/*
 * Package for the eight-bit period match timer: register offsets, field
 * positions, reset values, divider constants and the bus carrier types.
 * Assumes a classic Wishbone master with 32-bit address and data.
 */
package pmt_pkg;

	// ************************************************************
	// Bus widths and register offsets (byte addresses)
	// ************************************************************
	localparam int unsigned ADR_W = 32;
	localparam int unsigned DAT_W = 32;
	localparam int unsigned REG_W = 8;

	localparam logic [ADR_W-1:0] OFS_TIMER_COUNT  = 32'h0000_0000;
	localparam logic [ADR_W-1:0] OFS_PERIOD_VALUE = 32'h0000_0004;
	localparam logic [ADR_W-1:0] OFS_TIMER_CTRL   = 32'h0000_0008;
	localparam logic [ADR_W-1:0] OFS_PERIPH_FLAGS = 32'h0000_000c;
	localparam logic [ADR_W-1:0] OFS_PERIPH_ENAB  = 32'h0000_0010;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int unsigned CTL_PRE_LSB  = 0;
	localparam int unsigned CTL_PRE_MSB  = 1;
	localparam int unsigned CTL_RUN_BIT  = 2;
	localparam int unsigned CTL_POST_LSB = 3;
	localparam int unsigned CTL_POST_MSB = 6;
	localparam int unsigned CTL_RSVD_BIT = 7;

	// Prescale codes; any code with the upper bit set divides by 16.
	localparam logic [1:0] PRE_DIV1     = 2'b00;
	localparam logic [1:0] PRE_DIV4     = 2'b01;
	localparam logic [3:0] PRE_LAST_D4  = 4'h3;
	localparam logic [3:0] PRE_LAST_D16 = 4'hf;

	// Flag and enable position of the match interrupt.
	localparam int unsigned FLAG_MATCH_BIT = 1;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [REG_W-1:0] COUNT_RST  = 8'h00;
	localparam logic [REG_W-1:0] PERIOD_RST = 8'hff;
	localparam logic [REG_W-1:0] CTRL_RST   = 8'h00;
	localparam logic [REG_W-1:0] FLAGS_RST  = 8'h00;
	localparam logic [REG_W-1:0] ENAB_RST   = 8'h00;

	// ************************************************************
	// Instruction clock: core clock divided by four
	// ************************************************************
	localparam int unsigned INSTR_DIV  = 4;
	localparam logic [1:0]  INSTR_LAST = 2'(INSTR_DIV - 1);

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [3:0]       sel;
		logic [ADR_W-1:0] adr;
		logic [DAT_W-1:0] dat;
	} pmt_wb_req_t;

	typedef struct packed {
		logic             ack;
		logic [DAT_W-1:0] dat;
	} pmt_wb_rsp_t;

	typedef struct packed {
		logic pwm_match;
		logic shift_clk;
		logic gate_pulse;
	} pmt_tmr_out_t;

endpackage : pmt_pkg

//--- logic/pmt_timer8.sv
/*
 * Eight-bit period match timer with prescaler, postscaler, match interrupt
 * and a classic Wishbone register slave.
 * Assumes one clock, core_clk, at 250 MHz, an asynchronous active-high
 * reset that stands for every device reset, and a master that holds each
 * request until it samples ack.
 * The instruction phase runs free from reset and no register write
 * restarts it, so the first tick after a count or control write comes
 * one to four core clocks later; software that needs exact spacing must
 * allow for that phase.
 */
// Overview of operation
// - Count advances from zero on prescaled instruction ticks.
// - Prescale code 00 /1, 01 /4, 1x /16.
// - Compare count with period every cycle.
// - After match, reload zero; match clocks postscaler.
// - Reset clears count, sets period to ones.
// - Count or control write clears both scalers.
// - Control write keeps the count value.
// - Timer counts only while run bit set.
// - Postscale ratio is code plus one.
// - Completed postscale sets flag bit one.
// - Interrupt forwarded only when enable bit set.
// - Count and period readable and writable anytime.
// - Unscaled match goes to capture/PWM units.
// - Match output serves as serial shift clock.
// - Reload sends one instruction-cycle gate pulse.
`timescale 1ns/1ns

module pmt_timer8 (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire pmt_pkg::pmt_wb_req_t wb_req,
	output      pmt_pkg::pmt_wb_rsp_t wb_rsp,
	output      pmt_pkg::pmt_tmr_out_t tmr_out,
	output      logic                 irq
);
	import pmt_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	typedef enum logic [1:0] {
		PMT_BUS_IDLE = 2'b01,
		PMT_BUS_ACK  = 2'b10
	} pmt_bus_state_t;

	pmt_bus_state_t   bus_state_q;
	logic             ack_q;
	logic [DAT_W-1:0] rdat_q;
	logic [DAT_W-1:0] rdat_d;

	logic [REG_W-1:0] timer_count_q;
	logic [REG_W-1:0] period_value_q;
	logic [REG_W-1:0] timer_control_q;
	logic [REG_W-1:0] peripheral_enables_q;
	logic             match_irq_flag_q;

	logic [1:0]       instr_phase_q;
	logic [3:0]       prescale_cnt_q;
	logic [3:0]       postscale_cnt_q;
	logic [1:0]       gate_cnt_q;

	logic             pwm_match_q;
	logic             shift_clk_q;
	logic             gate_pulse_q;
	logic             irq_q;

	logic             access;
	logic             wr_lane0;
	logic             wr_count;
	logic             wr_period;
	logic             wr_ctrl;
	logic             wr_flags;
	logic             wr_enab;
	logic             rd_flags;
	logic             scaler_clear;
	logic             instr_tick;
	logic             pre_tick;
	logic             count_equal;
	logic             reload;
	logic             count_step;
	logic             post_done;
	logic [1:0]       prescale_select;
	logic [3:0]       postscale_select;
	logic             timer_run;

	// ************************************************************
	// Control fields
	// ************************************************************

	// Field views of the control register.
	assign prescale_select  = timer_control_q[CTL_PRE_MSB:CTL_PRE_LSB];
	assign postscale_select = timer_control_q[CTL_POST_MSB:CTL_POST_LSB];
	assign timer_run        = timer_control_q[CTL_RUN_BIT];

	// ************************************************************
	// Wishbone slave
	// ************************************************************

	// A request is taken once, in the cycle before ack is raised.
	assign access   = wb_req.cyc && wb_req.stb &&
	                  (bus_state_q == PMT_BUS_IDLE);
	assign wr_lane0 = access && wb_req.we && wb_req.sel[0];
	assign wr_count  = wr_lane0 && (wb_req.adr == OFS_TIMER_COUNT);
	assign wr_period = wr_lane0 && (wb_req.adr == OFS_PERIOD_VALUE);
	assign wr_ctrl   = wr_lane0 && (wb_req.adr == OFS_TIMER_CTRL);
	assign wr_flags  = wr_lane0 && (wb_req.adr == OFS_PERIPH_FLAGS);
	assign wr_enab   = wr_lane0 && (wb_req.adr == OFS_PERIPH_ENAB);
	assign rd_flags  = access && !wb_req.we &&
	                   (wb_req.adr == OFS_PERIPH_FLAGS);

	// Handshake: one wait state, then ack for exactly one cycle.
	// The ack state ignores the strobe that is still raised, so no
	// request is ever taken twice.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_state_q <= PMT_BUS_IDLE;
			ack_q       <= 1'b0;
		end else begin
			unique case (bus_state_q)
				PMT_BUS_IDLE: begin
					if (wb_req.cyc && wb_req.stb) begin
						bus_state_q <= PMT_BUS_ACK;
						ack_q       <= 1'b1;
					end
				end
				PMT_BUS_ACK: begin
					bus_state_q <= PMT_BUS_IDLE;
					ack_q       <= 1'b0;
				end
				default: begin
					bus_state_q <= PMT_BUS_IDLE;
					ack_q       <= 1'b0;
				end
			endcase
		end
	end

	// Read data; unmapped addresses and reserved bits read as zero.
	always_comb begin
		rdat_d = '0;
		unique case (wb_req.adr)
			OFS_TIMER_COUNT:  rdat_d[REG_W-1:0] = timer_count_q;
			OFS_PERIOD_VALUE: rdat_d[REG_W-1:0] = period_value_q;
			OFS_TIMER_CTRL: begin
				rdat_d[REG_W-1:0]    = timer_control_q;
				rdat_d[CTL_RSVD_BIT] = 1'b0;
			end
			OFS_PERIPH_FLAGS: rdat_d[FLAG_MATCH_BIT] = match_irq_flag_q;
			OFS_PERIPH_ENAB:  rdat_d[REG_W-1:0] = peripheral_enables_q;
			default:          rdat_d = '0;
		endcase
	end

	// Read data is captured with the request and held beside ack.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdat_q <= '0;
		end else if (access) begin
			rdat_q <= wb_req.we ? '0 : rdat_d;
		end
	end

	// The whole answer is driven at once, straight from its flip-flops.
	assign wb_rsp = '{ack: ack_q, dat: rdat_q};

	// ************************************************************
	// Registers written by software
	// ************************************************************

	// Period value; all ones after reset.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			period_value_q <= PERIOD_RST;
		end else if (wr_period) begin
			period_value_q <= wb_req.dat[REG_W-1:0];
		end
	end

	// Control register; bit seven is never stored.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timer_control_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			timer_control_q <= wb_req.dat[REG_W-1:0] &
			                   ~(REG_W'(1) << CTL_RSVD_BIT);
		end
	end

	// Interrupt mask, same layout as the flag register.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			peripheral_enables_q <= ENAB_RST;
		end else if (wr_enab) begin
			peripheral_enables_q <= wb_req.dat[REG_W-1:0];
		end
	end

	// ************************************************************
	// Instruction clock and prescaler
	// ************************************************************

	// Scaler counters restart on a count or control write.
	assign scaler_clear = wr_count || wr_ctrl;

	// Phase counter makes one tick per four core clocks.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			instr_phase_q <= 2'h0;
		end else begin
			instr_phase_q <= instr_phase_q + 2'h1;
		end
	end

	// Tick marks the last core clock of each instruction cycle.
	assign instr_tick = (instr_phase_q == INSTR_LAST);

	// Prescaler counts instruction ticks only while the timer runs.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prescale_cnt_q <= 4'h0;
		end else if (scaler_clear) begin
			prescale_cnt_q <= 4'h0;
		end else if (instr_tick && timer_run) begin
			prescale_cnt_q <= prescale_cnt_q + 4'h1;
		end
	end

	// Divider selection: direct, every fourth or every sixteenth tick.
	// Codes with the upper bit set share the divide-by-sixteen path.
	always_comb begin
		if (prescale_select == PRE_DIV1) begin
			pre_tick = instr_tick;
		end else if (prescale_select == PRE_DIV4) begin
			pre_tick = instr_tick &&
			           (prescale_cnt_q[1:0] == PRE_LAST_D4[1:0]);
		end else begin
			pre_tick = instr_tick &&
			           (prescale_cnt_q == PRE_LAST_D16);
		end
	end

	// ************************************************************
	// Count and period match
	// ************************************************************

	// Comparator runs every cycle.
	assign count_equal = (timer_count_q == period_value_q);

	// A tick moves the count only while the timer runs and no count or
	// control write lands in the same cycle; without the last term a
	// control write that met a tick would bump the count it must keep.
	assign count_step = pre_tick && timer_run &&
	                    !scaler_clear;

	// On the next increment after a match the count reloads zero, which
	// also feeds the postscaler, the shift clock and the gate pulse.
	assign reload = count_step && count_equal;

	// Timer count; a software write takes precedence over counting.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timer_count_q <= COUNT_RST;
		end else if (wr_count) begin
			timer_count_q <= wb_req.dat[REG_W-1:0];
		end else if (count_step) begin
			if (count_equal) begin
				timer_count_q <= COUNT_RST;
			end else begin
				timer_count_q <= timer_count_q + 8'h01;
			end
		end
		// A control write leaves the count alone.
	end

	// ************************************************************
	// Postscaler and interrupt flag
	// ************************************************************

	// The postscaler completes after select plus one matches.
	assign post_done = reload &&
	                   (postscale_cnt_q == postscale_select);

	// Postscale counter driven by the match reload.
	// A count or control write restarts the ratio from the first match.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			postscale_cnt_q <= 4'h0;
		end else if (scaler_clear) begin
			postscale_cnt_q <= 4'h0;
		end else if (post_done) begin
			postscale_cnt_q <= 4'h0;
		end else if (reload) begin
			postscale_cnt_q <= postscale_cnt_q + 4'h1;
		end
	end

	// Sticky flag: a read or a zero write clears it, a set wins.
	// Letting the clear win would lose an event that lands on the read.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			match_irq_flag_q <= FLAGS_RST[FLAG_MATCH_BIT];
		end else if (post_done) begin
			match_irq_flag_q <= 1'b1;
		end else if (rd_flags) begin
			match_irq_flag_q <= 1'b0;
		end else if (wr_flags) begin
			match_irq_flag_q <= wb_req.dat[FLAG_MATCH_BIT];
		end
	end

	// Interrupt output, high while the flag is set and enabled.
	// The enable only masks the output; the flag itself still sets.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= match_irq_flag_q &&
			         peripheral_enables_q[FLAG_MATCH_BIT];
		end
	end

	assign irq = irq_q;

	// ************************************************************
	// Outputs to neighbouring units
	// ************************************************************

	// Unscaled match level for the capture/PWM time base.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pwm_match_q <= 1'b0;
		end else begin
			pwm_match_q <= count_equal;
		end
	end

	// Serial shift clock toggles on every match reload.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_clk_q <= 1'b0;
		end else if (reload) begin
			shift_clk_q <= ~shift_clk_q;
		end
	end

	// Gate pulse lasts exactly one instruction cycle after a reload.
	// The counter keeps the pulse high for the rest of that cycle.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gate_cnt_q   <= 2'h0;
			gate_pulse_q <= 1'b0;
		end else if (reload) begin
			gate_cnt_q   <= INSTR_LAST;
			gate_pulse_q <= 1'b1;
		end else if (gate_cnt_q != 2'h0) begin
			gate_cnt_q   <= gate_cnt_q - 2'h1;
			gate_pulse_q <= 1'b1;
		end else begin
			gate_pulse_q <= 1'b0;
		end
	end

	// Neighbour outputs leave together, each from its own flip-flop.
	assign tmr_out = '{
		pwm_match:  pwm_match_q,
		shift_clk:  shift_clk_q,
		gate_pulse: gate_pulse_q
	};

endmodule : pmt_timer8

//--- verif/pmt_timer8_props.sv
/*
 * Checker for the period match timer ports: bus answer, gate pulse,
 * shift clock and quiet outputs during reset.
 * Assumes one clock, core_clk, and async active-high rst.
 */
`timescale 1ns/1ns

module pmt_timer8_props (
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire pmt_pkg::pmt_wb_req_t  wb_req,
	input wire pmt_pkg::pmt_wb_rsp_t  wb_rsp,
	input wire pmt_pkg::pmt_tmr_out_t tmr_out,
	input wire logic                  irq
);
	import pmt_pkg::*;
	// ****************************
	// Properties
	// ****************************
	// ****************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Steps of a bus request and of a reload pulse.
	sequence s_req_open;
		wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	endsequence
	sequence s_gate_start;
		$rose(tmr_out.gate_pulse);
	endsequence
	sequence s_gate_hold;
		tmr_out.gate_pulse [*4];
	endsequence

	AST_ACK_ANSWER: assert property (
		s_req_open |=> wb_rsp.ack) else $error("ack late");
	AST_ACK_PULSE: assert property (
		wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held");
	AST_RD_UPPER: assert property (
		wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
		else $error("upper data set");
	AST_GATE_LEN: assert property (
		s_gate_start |-> s_gate_hold ##1
		(!tmr_out.gate_pulse || $past(tmr_out.pwm_match)))
		else $error("gate pulse length");
	AST_GATE_CAUSE: assert property (
		s_gate_start |-> $past(tmr_out.pwm_match))
		else $error("reload without match");
	AST_SHIFT_CAUSE: assert property (
		$changed(tmr_out.shift_clk) |-> tmr_out.gate_pulse)
		else $error("shift clock moved alone");
	AST_SHIFT_TOGGLE: assert property (
		s_gate_start |-> $changed(tmr_out.shift_clk))
		else $error("shift clock missed reload");
	// Two reset edges: the first may meet flops not yet cleared.
	AST_RST_QUIET: assert property (disable iff (1'b0)
		rst [*2] |-> !wb_rsp.ack && wb_rsp.dat == '0 &&
		tmr_out == '0 && !irq) else $error("outputs in reset");
endmodule : pmt_timer8_props

bind pmt_timer8 pmt_timer8_props u_props (
	.core_clk(core_clk),
	.rst     (rst),
	.wb_req  (wb_req),
	.wb_rsp  (wb_rsp),
	.tmr_out (tmr_out),
	.irq     (irq)
);

//--- verif/pmt_timer8_bench.sv
/*
 * Self-checking bench for the period match timer.
 * Assumes the checker is bound and the bus answers one cycle late.
 */
`timescale 1ns/1ns

`define CHECK_EQ(got, exp) begin checks++; if ((got) !== (exp)) begin \
	mismatches++; $display("Error %0t: got %h want %h", $time, \
	(got), (exp)); end end

module pmt_timer8_bench;
	import pmt_pkg::*;
	// ****************************
	// Signals
	// ****************************
	logic         core_clk;
	logic         rst;
	pmt_wb_req_t  req;
	pmt_wb_rsp_t  rsp;
	pmt_tmr_out_t tout;
	logic         irq;
	int           mismatches;
	int           checks;
	int           cyc_n;
	int           rise_t;
	int           rises;
	int           t0;
	int           d;
	int unsigned  per;
	int unsigned  k;
	logic         gate_d;
	logic         en;
	logic         sclk;
	logic [7:0]   v;

	pmt_timer8 uut (
		.core_clk(core_clk),
		.rst     (rst),
		.wb_req  (req),
		.wb_rsp  (rsp),
		.tmr_out (tout),
		.irq     (irq)
	);

	// Gap in core clocks between reloads for a period and prescale code.
	function automatic int gap(int unsigned p, int unsigned c);
		return (p + 1) * INSTR_DIV * (c == 0 ? 1 : (c == 1 ? 4 : 16));
	endfunction : gap

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// One classic bus cycle; holds everything until ack is sampled.
	task automatic bus(input logic we, input logic [ADR_W-1:0] a,
		input logic [7:0] dat, output logic [7:0] r);
		req.cyc <= 1'b1;
		req.stb <= 1'b1;
		req.we  <= we;
		req.sel <= 4'h1;
		req.adr <= a;
		req.dat <= {24'h0, dat};
		do begin
			@(posedge core_clk);
		end while (rsp.ack !== 1'b1);
		r = rsp.dat[7:0];
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] dat);
		logic [7:0] r;
		bus(1'b1, a, dat, r);
	endtask : wr

	task automatic rd_cmp(input logic [ADR_W-1:0] a, input logic [7:0] e);
		logic [7:0] r;
		bus(1'b0, a, 8'h00, r);
		`CHECK_EQ(r, e)
	endtask : rd_cmp

	// Waits, bounded, until the reload counter reaches n.
	task automatic wait_rises(input int n);
		int lim;
		lim = 0;
		while (rises < n && lim < 3000) begin
			@(posedge core_clk);
			lim++;
		end
		`CHECK_EQ(rises >= n, 1'b1)
	endtask : wait_rises

	// Clock source.
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Counts cycles, timestamps gate pulse rises and cuts a hang short.
	always @(posedge core_clk) begin
		cyc_n <= cyc_n + 1;
		gate_d <= tout.gate_pulse;
		if (tout.gate_pulse === 1'b1 && gate_d === 1'b0) begin
			rise_t <= cyc_n;
			rises <= rises + 1;
		end
		if (cyc_n == 40000) begin
			mismatches++;
			final_report();
		end
	end

	// Main sequence of tests.
	initial begin
		req = '0;
		rst = 1'b1;
		{mismatches, checks, cyc_n, rise_t, rises} = '0;
		gate_d = 1'b0;
		void'($urandom(32'h4fc4a7b4));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd_cmp(OFS_TIMER_COUNT, COUNT_RST);
		rd_cmp(OFS_PERIOD_VALUE, PERIOD_RST);
		rd_cmp(OFS_TIMER_CTRL, CTRL_RST);
		rd_cmp(OFS_PERIPH_FLAGS, FLAGS_RST);
		wr(OFS_TIMER_CTRL, 8'h80);
		rd_cmp(OFS_TIMER_CTRL, 8'h00);
		rd_cmp(32'h0000_0014, 8'h00);
		rd_cmp(OFS_PERIPH_ENAB, ENAB_RST);
		wr(OFS_PERIPH_FLAGS, 8'h02);
		rd_cmp(OFS_PERIPH_FLAGS, 8'h02);
		wr(OFS_PERIPH_FLAGS, 8'h02);
		wr(OFS_PERIPH_FLAGS, 8'h00);
		rd_cmp(OFS_PERIPH_FLAGS, 8'h00);
		$display("test reset_values done");
		repeat (6) begin
			v = 8'($urandom);
			wr(OFS_TIMER_COUNT, v);
			wr(OFS_TIMER_CTRL, v & 8'h7b);
			rd_cmp(OFS_TIMER_CTRL, v & 8'h7b);
			wr(OFS_PERIOD_VALUE, v);
			`CHECK_EQ(tout.pwm_match, 1'b1)
			repeat (40) @(posedge core_clk);
			rd_cmp(OFS_TIMER_COUNT, v);
			wr(OFS_PERIOD_VALUE, ~v);
			rd_cmp(OFS_PERIOD_VALUE, ~v);
			`CHECK_EQ(tout.pwm_match, 1'b0)
		end
		$display("test register_access done");
		for (int code = 0; code < 4; code++) begin
			per = 1 + $urandom_range(4);
			wr(OFS_TIMER_CTRL, 8'h00);
			wr(OFS_PERIOD_VALUE, 8'(per));
			wr(OFS_TIMER_COUNT, 8'h00);
			wr(OFS_TIMER_CTRL, 8'h04 | 8'(code));
			wait_rises(rises + 1);
			t0 = rise_t;
			sclk = tout.shift_clk;
			wait_rises(rises + 1);
			`CHECK_EQ(rise_t - t0, gap(per, code))
			`CHECK_EQ(tout.shift_clk, ~sclk)
			repeat ($urandom_range(40, 100)) @(posedge core_clk);
			wr(OFS_TIMER_COUNT, 8'h00);
			t0 = cyc_n;
			wait_rises(rises + 1);
			d = rise_t - t0 - gap(per, code);
			`CHECK_EQ(d >= -6 && d <= 6, 1'b1)
		end
		$display("test prescale done");
		repeat (6) begin
			k = $urandom_range(15);
			en = 1'($urandom);
			per = 1 + $urandom_range(3);
			wr(OFS_TIMER_CTRL, 8'h00);
			wr(OFS_PERIOD_VALUE, 8'(per));
			wr(OFS_TIMER_COUNT, 8'h00);
			bus(1'b0, OFS_PERIPH_FLAGS, 8'h00, v);
			wr(OFS_PERIPH_ENAB, {6'h0, en, 1'b0});
			t0 = rises;
			wr(OFS_TIMER_CTRL, 8'(k << 3) | 8'h04);
			wait_rises(t0 + int'(k));
			repeat (2) @(posedge core_clk);
			`CHECK_EQ(irq, 1'b0)
			wait_rises(t0 + int'(k) + 1);
			repeat (3) @(posedge core_clk);
			`CHECK_EQ(irq, en)
			wr(OFS_TIMER_CTRL, 8'h00);
			rd_cmp(OFS_PERIPH_FLAGS, 8'h02);
			rd_cmp(OFS_PERIPH_FLAGS, 8'h00);
			`CHECK_EQ(irq, 1'b0)
		end
		$display("test postscale done");
		wr(OFS_PERIOD_VALUE, 8'h03);
		wr(OFS_TIMER_CTRL, 8'h7c);
		repeat (50) @(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd_cmp(OFS_TIMER_COUNT, COUNT_RST);
		rd_cmp(OFS_PERIOD_VALUE, PERIOD_RST);
		rd_cmp(OFS_TIMER_CTRL, CTRL_RST);
		`CHECK_EQ(tout, 3'h0)
		`CHECK_EQ(irq, 1'b0)
		$display("test reset_midrun done");
		final_report();
	end
endmodule : pmt_timer8_bench
